// [logic/field_move_defs.vh]
// constants for the field move cycle timing block
// What this block does
// [RL1] class A: sixteen bits wide, start and end on word boundaries
// [RL2] under sixteen bits: B1 end aligned, B2 start aligned, else B3
// [RL3] class B3 only inside one word, so at most fourteen bits
// [RL4] class C: thirty-two bits wide, start and end on word boundaries
// [RL5] class D: over sixteen bits, start unaligned, end on a word end
// [RL6] class E: over sixteen bits, start aligned, end not on a word end
// [RL7] class F crosses one boundary unaligned; class G crosses two, 18 to 32 bits
// [RL8] memory-to-register moves carry no hidden write states
// [RL9] indirect long load: 3,5,7 on cache hit and 6,8,10 cache disabled
// [RL10] a sign-extending load costs one more state
// [RL11] indirect long store: one visible plus 1,3,5,7,9 hidden by class
// [RL12] each entry gives hit and disabled counts, hidden states kept apart
// [RL13] memory-to-memory column index comes from source and destination classes
// [RL14] indirect long copy: 3+(1),7 at index 1 up to 9+(9),21 at 13
// [RL15] duration depends on cache state, field size and word alignment
// [RL16] external delays such as wait states lengthen actual execution
// [RL17] hidden writes overlap later work; bus users stall; at most nine pending; here no request is taken until none are pending
// [RL18] report visible and hidden counts for every form, class and cache case
`ifndef FIELD_MOVE_DEFS_VH
`define FIELD_MOVE_DEFS_VH

// ----------------------------------------
// alignment classes
// ----------------------------------------
`define ALN_A 3'h0
`define ALN_B 3'h1
`define ALN_C 3'h2
`define ALN_D 3'h3
`define ALN_E 3'h4
`define ALN_F 3'h5
`define ALN_G 3'h6
`define SUB_NONE 2'h0
`define SUB_B1 2'h1
`define SUB_B2 2'h2
`define SUB_B3 2'h3
`define WORD_BITS 6'h10
`define LONG_BITS 6'h20

// ----------------------------------------
// move kinds and form counts
// ----------------------------------------
`define KIND_M2R 2'h0
`define KIND_R2M 2'h1
`define KIND_M2M 2'h2
`define M2R_FORMS 4'h8
`define R2M_FORMS 4'h8
`define M2M_FORMS 4'hA
`define SIGN_EXT_STATES 6'h01

// ----------------------------------------
// entry layout: visible, hidden, cache disabled
// ----------------------------------------
`define ENT_VIS_LSB 12
`define ENT_HID_LSB 8
`define ENT_DIS_LSB 0
`define ENT_BITS 16

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_PENDING 4'h0
`define RST_COUNT 6'h00
`define RST_INDEX 4'h0

// ----------------------------------------
// load rows: A or B, C to F, G
// ----------------------------------------
`define M2R_ROW0 48'h3006_5008_0000
`define M2R_ROW1 48'h500B_700D_0000
`define M2R_ROW2 48'h500E_7010_0000
`define M2R_ROW3 48'h3006_5008_700A
`define M2R_ROW4 48'h3006_5008_700A
`define M2R_ROW5 48'h4007_6009_800B
`define M2R_ROW6 48'h500B_700D_900F
`define M2R_ROW7 48'h500E_7010_9013

// ----------------------------------------
// store rows: A, B or C, D or E, F, G
// ----------------------------------------
`define R2M_ROW0 80'h0000_1307_0000_170B_0000
`define R2M_ROW1 80'h0000_3307_0000_370D_0000
`define R2M_ROW2 80'h0000_1307_0000_370D_0000
`define R2M_ROW3 80'h1105_1307_1509_170B_190D
`define R2M_ROW4 80'h1105_1307_1509_170B_190D
`define R2M_ROW5 80'h2106_2308_250A_270C_290E
`define R2M_ROW6 80'h3107_3309_350B_370D_390F
`define R2M_ROW7 80'h3107_3309_350B_370D_390F

// ----------------------------------------
// copy rows: index 1 in the top entry
// ----------------------------------------
`define M2M_ROW0 208'h0000_3307_370D_0000_530B_0000_0000_570F_0000_0000_0000_0000_0000
`define M2M_ROW1 208'h0000_5307_5715_0000_630D_0000_0000_7713_0000_0000_0000_0000_0000
`define M2M_ROW2 208'h0000_7307_771D_0000_630C_0000_0000_971B_0000_0000_0000_0000_0000
`define M2M_ROW3 208'h3107_3309_370D_5109_530B_530B_550D_570F_5911_730D_750F_5711_9915
`define M2M_ROW4 208'h4007_4209_460D_6009_620B_620B_640D_660F_6811_820D_840F_6611_A815
`define M2M_ROW5 208'h4108_430A_470E_610A_630C_630C_650E_670F_6912_830E_8510_6712_A916
`define M2M_ROW6 208'h510C_530E_5712_710E_7310_730D_750F_7710_7913_9312_9514_7716_B91A
`define M2M_ROW7 208'h510F_5311_5715_7111_7313_7310_7512_7713_7916_9315_9517_7719_B91D
`define M2M_ROW8 208'h510F_5311_5715_7111_7313_7310_7512_7713_7916_9315_9517_7719_B91D
`define M2M_ROW9 208'h7117_7319_771D_9119_931B_9318_951A_971B_991E_B31D_B51F_9721_D925
`define M2M_ENTRIES 4'hD

// ----------------------------------------
// copy index by source class, destination A in top nibble
// ----------------------------------------
`define IDX_SRC_A 28'h1000030
`define IDX_SRC_B 28'h0200031
`define IDX_SRC_C 28'h0060009
`define IDX_SRC_D 28'h0007789
`define IDX_SRC_E 28'h0007789
`define IDX_SRC_F 28'h4507789
`define IDX_SRC_G 28'h00ABBCD

`endif

// [logic/field_align_classify.v]
// field alignment class from bit offset and field size
`timescale 1ns/100ps
`default_nettype none
`include "field_move_defs.vh"

module field_align_classify (
    input  wire [3:0] bit_offset,
    input  wire [5:0] field_size,
    output reg  [2:0] align_class,
    output reg  [1:0] b_subcase,
    output reg        size_ok
);

    wire [6:0] end_sum;
    wire [6:0] last_bit;
    wire       start_al;
    wire       end_al;
    wire [1:0] last_word;

    assign end_sum   = {3'h0, bit_offset} + {1'h0, field_size};
    assign last_bit  = end_sum - 7'h01;
    assign start_al  = (bit_offset == 4'h0);
    assign end_al    = (end_sum[3:0] == 4'h0);
    assign last_word = last_bit[5:4];

    always @* begin
        align_class = `ALN_A;
        b_subcase   = `SUB_NONE;
        size_ok     = (field_size != 6'h00) && (field_size <= `LONG_BITS);
        if ((field_size == `WORD_BITS) && start_al) begin
            align_class = `ALN_A;                                 // RL1
        end else if ((field_size == `LONG_BITS) && start_al) begin
            align_class = `ALN_C;                                 // RL4
        end else if (field_size < `WORD_BITS) begin
            align_class = `ALN_B;                                 // RL2
            if (!start_al && end_al) begin
                b_subcase = `SUB_B1;                              // RL2
            end else if (start_al) begin
                b_subcase = `SUB_B2;                              // RL2
            end else if (last_word == 2'h0) begin
                // one word holds at most fourteen bits
                b_subcase = `SUB_B3;                              // RL3
            end else begin
                align_class = `ALN_F;                             // RL7
            end
        end else if (!start_al && end_al) begin
            align_class = `ALN_D;                                 // RL5
        end else if (start_al) begin
            align_class = `ALN_E;                                 // RL6
        end else if (last_word == 2'h1) begin
            align_class = `ALN_F;                                 // RL7
        end else begin
            align_class = `ALN_G;                                 // RL7
        end
    end

endmodule // field_align_classify
`default_nettype wire

// [logic/field_move_cycle_timing.v]
// field move cycle timing: class, table lookup and hidden write tracking
`timescale 1ns/100ps
`default_nettype none
`include "field_move_defs.vh"

module field_move_cycle_timing (
    input  wire       ref_clk,
    input  wire       rst_b,
    input  wire       req_valid,
    input  wire [1:0] req_kind,
    input  wire [3:0] req_form,
    input  wire [3:0] src_offset,
    input  wire [3:0] dst_offset,
    input  wire [5:0] field_size,
    input  wire       cache_off,
    input  wire       sign_ext,
    input  wire       ext_wait,
    output wire       req_ready,
    output wire       res_valid,
    output wire       res_na,
    output wire [5:0] res_visible,
    output wire [3:0] res_hidden,
    output wire [2:0] res_src_class,
    output wire [2:0] res_dst_class,
    output wire [1:0] res_src_sub,
    output wire [1:0] res_dst_sub,
    output wire [3:0] res_index,
    output wire [3:0] hidden_pending,
    output wire       hidden_busy
);

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    reg        rst_meta_b_r;
    reg        rst_sync_b_r;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b_r <= 1'b0;
            rst_sync_b_r <= 1'b0;
        end else begin
            rst_meta_b_r <= 1'b1;
            rst_sync_b_r <= rst_meta_b_r;
        end
    end

    // ----------------------------------------
    // field classification
    // ----------------------------------------
    wire [2:0] src_class;
    wire [2:0] dst_class;
    wire [1:0] src_sub;
    wire [1:0] dst_sub;
    wire       src_ok;
    wire       dst_ok;

    field_align_classify u_src_class (
        .bit_offset  (src_offset),
        .field_size  (field_size),
        .align_class (src_class),
        .b_subcase   (src_sub),
        .size_ok     (src_ok)
    );

    field_align_classify u_dst_class (
        .bit_offset  (dst_offset),
        .field_size  (field_size),
        .align_class (dst_class),
        .b_subcase   (dst_sub),
        .size_ok     (dst_ok)
    );

    // ----------------------------------------
    // copy column index
    // ----------------------------------------
    reg [27:0] idx_row;
    reg [3:0]  copy_index;
    reg [4:0]  idx_pos;

    always @* begin
        idx_row = 28'h0000000;
        case (src_class)
            `ALN_A: idx_row = `IDX_SRC_A;  // RL13
            `ALN_B: idx_row = `IDX_SRC_B;  // RL13
            `ALN_C: idx_row = `IDX_SRC_C;  // RL13
            `ALN_D: idx_row = `IDX_SRC_D;  // RL13
            `ALN_E: idx_row = `IDX_SRC_E;  // RL13
            `ALN_F: idx_row = `IDX_SRC_F;  // RL13
            `ALN_G: idx_row = `IDX_SRC_G;  // RL13
            default: idx_row = 28'h0000000;
        endcase
        idx_pos    = {(3'h6 - dst_class), 2'h0};
        copy_index = idx_row[idx_pos +: 4];  // RL13
    end

    // ----------------------------------------
    // load and store columns
    // ----------------------------------------
    reg [1:0] m2r_col;
    reg [2:0] r2m_col;

    always @* begin
        case (src_class)
            `ALN_A, `ALN_B: m2r_col = 2'h0;
            `ALN_G:         m2r_col = 2'h2;
            default:        m2r_col = 2'h1;
        endcase
        case (dst_class)
            `ALN_A:         r2m_col = 3'h0;
            `ALN_B, `ALN_C: r2m_col = 3'h1;
            `ALN_D, `ALN_E: r2m_col = 3'h2;
            `ALN_F:         r2m_col = 3'h3;
            default:        r2m_col = 3'h4;
        endcase
    end

    // ----------------------------------------
    // table rows
    // ----------------------------------------
    reg [47:0]  m2r_row;
    reg [79:0]  r2m_row;
    reg [207:0] m2m_row;

    always @* begin
        case (req_form[2:0])
            3'h0: m2r_row = `M2R_ROW0;
            3'h1: m2r_row = `M2R_ROW1;
            3'h2: m2r_row = `M2R_ROW2;
            3'h3: m2r_row = `M2R_ROW3;  // RL9
            3'h4: m2r_row = `M2R_ROW4;  // RL9
            3'h5: m2r_row = `M2R_ROW5;
            3'h6: m2r_row = `M2R_ROW6;
            default: m2r_row = `M2R_ROW7;
        endcase
        case (req_form[2:0])
            3'h0: r2m_row = `R2M_ROW0;
            3'h1: r2m_row = `R2M_ROW1;
            3'h2: r2m_row = `R2M_ROW2;
            3'h3: r2m_row = `R2M_ROW3;  // RL11
            3'h4: r2m_row = `R2M_ROW4;  // RL11
            3'h5: r2m_row = `R2M_ROW5;
            3'h6: r2m_row = `R2M_ROW6;
            default: r2m_row = `R2M_ROW7;
        endcase
        case (req_form)
            4'h0: m2m_row = `M2M_ROW0;
            4'h1: m2m_row = `M2M_ROW1;
            4'h2: m2m_row = `M2M_ROW2;
            4'h3: m2m_row = `M2M_ROW3;  // RL14
            4'h4: m2m_row = `M2M_ROW4;
            4'h5: m2m_row = `M2M_ROW5;
            4'h6: m2m_row = `M2M_ROW6;
            4'h7: m2m_row = `M2M_ROW7;
            4'h8: m2m_row = `M2M_ROW8;
            4'h9: m2m_row = `M2M_ROW9;
            default: m2m_row = 208'h0;
        endcase
    end

    // ----------------------------------------
    // entry lookup
    // ----------------------------------------
    reg [15:0] entry;
    reg [7:0]  ent_pos;
    reg        form_ok;
    reg        field_ok;

    always @* begin
        entry    = 16'h0000;
        ent_pos  = 8'h00;
        form_ok  = 1'b0;
        field_ok = 1'b0;
        case (req_kind)
            `KIND_M2R: begin
                form_ok  = (req_form < `M2R_FORMS);
                field_ok = src_ok;
                ent_pos  = {2'h0, (2'h2 - m2r_col), 4'h0};
                entry    = m2r_row[ent_pos[5:0] +: 16];  // RL15
            end
            `KIND_R2M: begin
                form_ok  = (req_form < `R2M_FORMS);
                field_ok = dst_ok;
                ent_pos  = {1'h0, (3'h4 - r2m_col), 4'h0};
                entry    = r2m_row[ent_pos[6:0] +: 16];  // RL15
            end
            `KIND_M2M: begin
                form_ok  = (req_form < `M2M_FORMS) && (copy_index != 4'h0);
                field_ok = src_ok && dst_ok;
                ent_pos  = {(`M2M_ENTRIES - copy_index), 4'h0};
                entry    = m2m_row[ent_pos +: 16];  // RL13
            end
            default: begin
                entry = 16'h0000;
            end
        endcase
    end

    // ----------------------------------------
    // counts for the chosen cache case
    // ----------------------------------------
    wire [3:0] ent_vis;
    wire [3:0] ent_hid;
    wire [7:0] ent_dis;
    reg        na_nxt;
    reg  [5:0] vis_nxt;
    reg  [3:0] hid_nxt;
    reg  [5:0] extra;

    assign ent_vis = entry[`ENT_VIS_LSB +: 4];
    assign ent_hid = entry[`ENT_HID_LSB +: 4];
    assign ent_dis = entry[`ENT_DIS_LSB +: 8];

    always @* begin
        na_nxt  = !form_ok || !field_ok || (entry == 16'h0000);
        extra   = 6'h00;
        vis_nxt = `RST_COUNT;
        hid_nxt = 4'h0;
        if ((req_kind == `KIND_M2R) && sign_ext) begin
            extra = `SIGN_EXT_STATES;  // RL10
        end
        if (!na_nxt) begin
            if (cache_off) begin
                // disabled count includes the writes
                vis_nxt = ent_dis[5:0] + extra;  // RL12
            end else begin
                vis_nxt = {2'h0, ent_vis} + extra;  // RL12
                hid_nxt = ent_hid;                  // RL11
            end
            if (req_kind == `KIND_M2R) begin
                hid_nxt = 4'h0;  // RL8
            end
        end
    end

    // ----------------------------------------
    // hidden write tracking
    // ----------------------------------------
    reg  [3:0] pending_r;
    reg  [3:0] pending_nxt;
    reg        ready_r;
    wire       accept;

    assign accept = req_valid && ready_r;  // RL17

    always @* begin
        pending_nxt = pending_r;
        if (accept && !na_nxt) begin
            pending_nxt = hid_nxt;  // RL17
        end else if ((pending_r != 4'h0) && !ext_wait) begin
            pending_nxt = pending_r - 4'h1;  // RL16
        end
    end

    // ----------------------------------------
    // result registers
    // ----------------------------------------
    reg       valid_r;
    reg       na_r;
    reg [5:0] vis_r;
    reg [3:0] hid_r;
    reg [2:0] src_class_r;
    reg [2:0] dst_class_r;
    reg [1:0] src_sub_r;
    reg [1:0] dst_sub_r;
    reg [3:0] index_r;
    reg       busy_r;

    always @(posedge ref_clk or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            pending_r   <= `RST_PENDING;
            ready_r     <= 1'b0;
            busy_r      <= 1'b0;
            valid_r     <= 1'b0;
            na_r        <= 1'b0;
            vis_r       <= `RST_COUNT;
            hid_r       <= 4'h0;
            src_class_r <= `ALN_A;
            dst_class_r <= `ALN_A;
            src_sub_r   <= `SUB_NONE;
            dst_sub_r   <= `SUB_NONE;
            index_r     <= `RST_INDEX;
        end else begin
            pending_r <= pending_nxt;
            // moves wait out pending writes
            ready_r   <= (pending_nxt == 4'h0);  // RL17
            busy_r    <= (pending_nxt != 4'h0);  // RL17
            valid_r   <= accept;
            if (accept) begin
                na_r        <= na_nxt;
                vis_r       <= vis_nxt;   // RL18
                hid_r       <= hid_nxt;   // RL18
                src_class_r <= src_class;
                dst_class_r <= dst_class;
                src_sub_r   <= src_sub;
                dst_sub_r   <= dst_sub;
                index_r     <= (req_kind == `KIND_M2M) ? copy_index : `RST_INDEX;
            end
        end
    end

    assign req_ready      = ready_r;
    assign res_valid      = valid_r;
    assign res_na         = na_r;
    assign res_visible    = vis_r;
    assign res_hidden     = hid_r;
    assign res_src_class  = src_class_r;
    assign res_dst_class  = dst_class_r;
    assign res_src_sub    = src_sub_r;
    assign res_dst_sub    = dst_sub_r;
    assign res_index      = index_r;
    assign hidden_pending = pending_r;
    assign hidden_busy    = busy_r;

endmodule // field_move_cycle_timing
`default_nettype wire

// [sim/fmt_monitor.sv]
// checker on the timing block ports
`timescale 1ns/100ps
`default_nettype none
module fmt_monitor (
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic       req_valid,
    input wire logic [1:0] req_kind,
    input wire logic [3:0] req_form,
    input wire logic [3:0] src_offset,
    input wire logic [5:0] field_size,
    input wire logic       cache_off,
    input wire logic       ext_wait,
    input wire logic       req_ready,
    input wire logic       res_valid,
    input wire logic [5:0] res_visible,
    input wire logic [3:0] res_hidden,
    input wire logic [2:0] res_src_class,
    input wire logic [1:0] res_src_sub,
    input wire logic [3:0] hidden_pending,
    input wire logic       hidden_busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // ----------------
    // request steps
    // ----------------
    sequence acc_s;
        req_valid && req_ready;
    endsequence
    sequence acc_hit_s;
        acc_s ##0 !cache_off;
    endsequence
    answer_pulse_a:
        assert property (acc_s |=> res_valid) else $error("no result");
    no_stray_a:
        assert property (!(req_valid && req_ready) |=> !res_valid) else $error("stray result");
    load_nohid_a:
        assert property (acc_s ##0 req_kind == 2'h0 |=> res_hidden == 4'h0 && hidden_pending == 4'h0)
            else $error("load hidden");
    cache_off_a:
        assert property (acc_s ##0 cache_off |=> res_hidden == 4'h0) else $error("hidden cache off");
    pend_start_a:
        assert property (res_valid |-> hidden_pending == res_hidden) else $error("pending load");
    countdown_a:
        assert property (hidden_pending != 4'h0 && !ext_wait && !req_ready
            |=> hidden_pending == $past(hidden_pending) - 4'h1) else $error("no countdown");
    wait_freeze_a:
        assert property (hidden_pending != 4'h0 && ext_wait && !req_ready |=> $stable(hidden_pending))
            else $error("moved in wait");
    stall_a:
        assert property (hidden_pending > 4'h1 |-> !req_ready && hidden_busy) else $error("no stall");
    max_hidden_a:
        assert property (hidden_pending <= 4'h9 && res_hidden <= 4'h9) else $error("over nine");
    class_a_a:
        assert property (acc_s ##0 field_size == 6'h10 && src_offset == 4'h0 |=> res_src_class == 3'h0)
            else $error("not class A");
    class_d_a:
        assert property (acc_s ##0 field_size > 6'h10 && src_offset != 4'h0
            && ({3'h0, src_offset} + {1'b0, field_size}) == 7'h20 |=> res_src_class == 3'h3)
            else $error("not class D");
    store_vis_a:
        assert property (acc_hit_s ##0 req_kind == 2'h1 && req_form == 4'h3 && field_size != 6'h00
            && field_size <= 6'h20 |=> res_visible == 6'h01) else $error("store visible");
endmodule // fmt_monitor
`default_nettype wire

// [sim/mem_wait_model.sv]
// far-side memory wait-state model
`timescale 1ns/100ps
`default_nettype none
module mem_wait_model (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic hidden_busy,
    input  wire logic slow,
    output var  logic ext_wait
);
    logic [1:0] ph_r;
    // slow mode adds wait states
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ph_r <= 2'h0;
            ext_wait <= 1'b0;
        end else begin
            ph_r <= ph_r + 2'h1;
            ext_wait <= slow && hidden_busy && ph_r != 2'h3;
        end
    end
endmodule // mem_wait_model
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the timing block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    typedef struct {logic na, cls; logic [5:0] vis; logic [3:0] hid; logic [4:0] sc, dc; logic [3:0] idx;} exp_t;
    logic            ref_clk, rst_b, req_valid, cache_off, sign_ext, slow;
    logic [1:0]      req_kind;
    logic [3:0]      req_form, src_offset, dst_offset;
    logic [5:0]      field_size;
    wire logic       ext_wait, req_ready, res_valid, res_na, hidden_busy;
    wire logic [5:0] res_visible;
    wire logic [3:0] res_hidden, res_index, hidden_pending;
    wire logic [2:0] res_src_class, res_dst_class;
    wire logic [1:0] res_src_sub, res_dst_sub;
    int              mismatches, checks, seed;
    exp_t            q[$];
    int              ld_hit[8] = '{3, 5, 5, 3, 3, 4, 5, 5};
    int              ld_dis[8] = '{6, 11, 14, 6, 6, 7, 11, 14};
    int              st_vis[8] = '{1, 3, 1, 1, 1, 2, 3, 3};
    logic [27:0]     idx_t[7] = '{28'h1000030, 28'h0200031, 28'h0060009, 28'h0007789, 28'h0007789,
                                  28'h4507789, 28'h00ABBCD};
    field_move_cycle_timing DUT (.ref_clk, .rst_b, .req_valid, .req_kind, .req_form, .src_offset, .dst_offset,
        .field_size, .cache_off, .sign_ext, .ext_wait, .req_ready, .res_valid, .res_na, .res_visible, .res_hidden,
        .res_src_class, .res_dst_class, .res_src_sub, .res_dst_sub, .res_index, .hidden_pending, .hidden_busy);
    mem_wait_model mem (.ref_clk, .rst_b, .hidden_busy, .slow, .ext_wait);
    // ----------------
    // expectations
    // ----------------
    function automatic logic [4:0] cls(input logic [3:0] o, input logic [5:0] s);
        int e;
        e = o + s;
        if (o == 0 && s == 16) return 5'h00;
        if (o == 0 && s == 32) return 5'h08;
        if (s < 16 && e == 16) return 5'h05;
        if (s < 16 && o == 0) return 5'h06;
        if (s < 16 && e < 16) return 5'h07;
        if (s > 16 && e % 16 == 0) return 5'h0C;
        if (s > 16 && o == 0) return 5'h10;
        return e > 32 ? 5'h18 : 5'h14;
    endfunction
    function automatic exp_t mk(input logic [1:0] k, input logic [3:0] f, so, d, input logic [5:0] sz,
                                input logic co, se, input logic [10:0] cp);
        exp_t        e;
        int          c, col, v, h, ds;
        logic [27:0] r;
        e.sc = cls(so, sz);
        e.dc = cls(d, sz);
        e.cls = sz != 0 && sz <= 32 && k != 2'h3;
        r = idx_t[e.sc[4:2]] >> (24 - 4 * e.dc[4:2]);
        e.idx = k == 2'h2 ? r[3:0] : 4'h0;
        c = k == 2'h0 ? e.sc[4:2] : e.dc[4:2];
        if (k == 2'h0) begin
            col = c < 2 ? 0 : c == 6 ? 2 : 1;
            h = 0;
            v = ld_hit[f[2:0]] + 2 * col;
            ds = ld_dis[f[2:0]] + 2 * col + (f == 7 && col == 2);
            e.na = f < 3 && col == 2;
        end else if (k == 2'h1) begin
            col = c == 0 ? 0 : c < 3 ? 1 : c < 5 ? 2 : c - 2;
            h = 2 * col + 1;
            v = st_vis[f[2:0]] + (f == 2 && col == 3 ? 2 : 0);
            ds = v + h + 3 - (f == 1 && col == 1 ? 2 : 0);
            e.na = f < 3 && col != 1 && col != 3;
        end else begin
            v = cp[9:4];
            h = cp[3:0];
            ds = v;
            e.na = cp[10];
        end
        if (co) begin
            v = ds;
            h = 0;
        end
        if (k == 2'h0 && se) v++;
        e.na = e.na || !e.cls;
        e.vis = e.na ? 6'h00 : 6'(v);
        e.hid = e.na ? 4'h0 : 4'(h);
        return e;
    endfunction
    // ----------------
    // drivers and compare
    // ----------------
    task automatic chk(input string what, input logic [7:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic send(input logic [1:0] k, input logic [3:0] f, so, d, input logic [5:0] sz,
                        input logic co, se, input logic [10:0] cp = 0);
        int n;
        req_valid = 1'b1;
        {req_kind, req_form, src_offset, dst_offset, field_size, cache_off, sign_ext} = {k, f, so, d, sz, co, se};
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 80);
        q.push_back(mk(k, f, so, d, sz, co, se, cp));
        @(posedge ref_clk);
        #1;
    endtask
    task automatic idle(input int c);
        req_valid = 1'b0;
        repeat (c) @(posedge ref_clk);
        #1;
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(negedge ref_clk) begin
        exp_t e;
        if (res_valid === 1'b1) begin
            e = q.pop_front();
            chk("na", res_na, e.na);
            chk("visible", res_visible, e.vis);
            chk("hidden", res_hidden, e.hid);
            if (!e.na) begin
                chk("source class", {3'h0, res_src_class, res_src_sub}, {3'h0, e.sc});
                chk("dest class", {3'h0, res_dst_class, res_dst_sub}, {3'h0, e.dc});
                chk("index", {4'h0, res_index}, {4'h0, e.idx});
            end
        end
    end
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        #500000;
        mismatches++;
        end_of_test();
    end
    initial begin
        int          f, i;
        logic [3:0]  toff[7] = '{0, 0, 0, 4, 0, 9, 5};
        logic [5:0]  tsz[7] = '{16, 8, 32, 28, 20, 10, 31};
        int          cf[9] = '{3, 3, 9, 3, 0, 4, 2, 0, 9};
        logic [3:0]  cso[9] = '{0, 0, 5, 5, 0, 0, 0, 0, 5};
        logic [3:0]  cd[9] = '{0, 0, 0, 3, 8, 0, 1, 0, 0};
        logic [5:0]  csz[9] = '{16, 16, 31, 31, 8, 32, 16, 16, 31};
        logic [10:0] ccp[9] = '{11'h031, 11'h070, 11'h0B5, 11'h099, 11'h033, 11'h062, 11'h077, 11'h400, 11'h1F0};
        mismatches = 0;
        checks = 0;
        seed = 32'h46ED39B4;
        rst_b = 1'b0;
        req_valid = 1'b0;
        {req_kind, req_form, src_offset, dst_offset, field_size, cache_off, sign_ext, slow} = '0;
        repeat (5) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        // loads then stores, all forms and classes
        for (f = 0; f < 32; f++) begin
            slow = f[4] & f[0];
            for (i = 0; i < 7; i++)
                send({1'b0, f[4]}, {1'b0, f[2:0]}, toff[i], toff[i], tsz[i], f[3], 1'($random(seed)));
        end
        $display("test tables done");
        for (i = 0; i < 9; i++)
            send(2'h2, cf[i][3:0], cso[i], cd[i], csz[i], i == 1 || i == 8, 1'b0, ccp[i]);
        $display("test copy done");
        send(2'h0, 4'h3, 4'h0, 4'h0, 6'h00, 1'b0, 1'b0);
        send(2'h1, 4'h3, 4'h0, 4'h0, 6'h21, 1'b0, 1'b0);
        send(2'h3, 4'h0, 4'h0, 4'h0, 6'h10, 1'b0, 1'b0);
        $display("test refused done");
        for (i = 0; i < 150; i++) begin
            slow = 1'($random(seed));
            send({1'b0, 1'($random(seed))}, {1'b0, 3'($random(seed))}, 4'($random(seed)), 4'($random(seed)),
                 6'(($random(seed) & 31) + 1), 1'($random(seed)), 1'($random(seed)));
            if (i % 10 == 0)
                idle(3);
        end
        $display("test random done");
        idle(60);
        chk("results left", 8'(q.size()), 8'h00);
        end_of_test();
    end
endmodule // tb_top
bind field_move_cycle_timing fmt_monitor mon (.ref_clk, .rst_b, .req_valid, .req_kind, .req_form, .src_offset,
    .field_size, .cache_off, .ext_wait, .req_ready, .res_valid, .res_visible, .res_hidden, .res_src_class,
    .res_src_sub, .hidden_pending, .hidden_busy);
`default_nettype wire
